// File: hw/wtc_ctrl.sv
/*
 waveform timer control slice: register port, command crossing, one-ramp
 waveform with override, event channels and interrupt requests.
 assumes inputs synchronous to ref_clk and a master that keeps strobes
 one cycle long; crossing into the timer domain is modelled as a fixed delay.
*/
`timescale 1ns/10ps
module wtc_event_ch (
   input  wire logic       ref_clk,
   input  wire logic       rst_n,
   input  wire logic       ev_in,
   input  wire logic [7:0] cfg,
   output logic            fault,
   output logic            direct_fault,
   output logic            capture_p,
   output logic            trig_p
);
   logic [1:0] mode;
   logic       samp_q;
   logic       filt_q;
   logic [1:0] fcnt_q;
   logic       lvl;
   logic       act;
   logic       act_prev_q;
   logic       cap_q;
   logic       trig_q;

   assign mode = cfg[7:6];

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         samp_q <= 1'b0;
      end else begin
         samp_q <= ev_in;
      end
   end

   // in filter mode a glitch shorter than four samples never reaches capture logic
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         filt_q <= 1'b0;
         fcnt_q <= 2'h0;
      end else if (ev_in == filt_q) begin
         fcnt_q <= 2'h0;
      end else if (fcnt_q == wtc_pkg::FILT_LAST) begin
         filt_q <= ev_in;
         fcnt_q <= 2'h0;
      end else begin
         fcnt_q <= fcnt_q + 2'h1;
      end
   end

   always_comb begin
      case (mode)
         wtc_pkg::EV_CFG_FILTER: lvl = filt_q;
         default:                lvl = samp_q;
      endcase
   end

   assign act = cfg[wtc_pkg::B_EV_EDGE] ? lvl : ~lvl;
   // direct path bypasses every flop so it works with the timer clock off
   assign direct_fault = (mode == wtc_pkg::EV_CFG_DIRECT)
                       & (cfg[wtc_pkg::B_EV_EDGE] ? ev_in : ~ev_in);
   assign fault = (mode == wtc_pkg::EV_CFG_DIRECT) ? direct_fault : act;

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         act_prev_q <= 1'b0;
         cap_q      <= 1'b0;
         trig_q     <= 1'b0;
      end else begin
         act_prev_q <= act;
         cap_q      <= act & ~act_prev_q & cfg[wtc_pkg::B_EV_ACTION];
         trig_q     <= act & ~act_prev_q & cfg[wtc_pkg::B_EV_TRIG];
      end
   end

   assign capture_p = cap_q;
   assign trig_p    = trig_q;

   filter_four_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      $changed(filt_q) |-> ($past(ev_in, 1) == filt_q) && ($past(ev_in, 2) == filt_q)
                        && ($past(ev_in, 3) == filt_q) && ($past(ev_in, 4) == filt_q))
      else $error("filter changed before four equal samples");
endmodule : wtc_event_ch

module wtc_ctrl #(
   parameter logic [11:0] PHASE_LEN = 12'h400
) (
   input  wire logic           ref_clk,
   input  wire logic           rst_n,
   input  wtc_pkg::wtc_bus_s   bus,
   output logic [7:0]          rdata,
   input  wire logic           event_a_in,
   input  wire logic           event_b_in,
   output wtc_pkg::wtc_wave_s  waveform,
   output logic                fault_a,
   output logic                fault_b,
   output logic                capture_a,
   output logic                capture_b,
   output logic                buffer_load,
   output logic                timer_running,
   output logic [2:0]          irq_req
);
   localparam logic [11:0] PHASE_LAST = PHASE_LEN - 12'h001;

   logic                 en_reg_q;
   logic [1:0]           en_cnt_q;
   logic                 timer_en_q;
   logic                 dis_pend_q;
   logic                 ovr_en_q;
   logic [7:0]           ovr_val_q;
   logic [7:0]           ev_a_q;
   logic [7:0]           ev_b_q;
   logic [7:0]           irq_en_q;
   logic [7:0]           flags_q;
   logic [7:0]           rdata_q;
   logic [4:0]           cmd_q;
   logic [1:0]           cmd_cnt_q;
   logic                 eoc_pend_q;
   logic                 cap_a_q;
   logic                 cap_b_q;
   logic                 load_q;
   logic [11:0]          ph_cnt_q;
   wtc_pkg::wtc_phase_e  phase_q;
   wtc_pkg::wtc_phase_e  phase_d;
   wtc_pkg::wtc_wave_s   wave_q;
   wtc_pkg::wtc_wave_s   wave_d;
   logic [2:0]           irq_q;
   logic                 wr_cmd;
   logic                 cmd_accept;
   logic                 dis_accept;
   logic                 arrive;
   logic                 cyc_end;
   logic                 cmd_ready;
   logic                 en_ready;
   logic                 restart;
   logic [7:0]           flag_set;
   logic [7:0]           flag_clr;
   logic                 ev_a_fault;
   logic                 ev_b_fault;
   logic                 ev_a_direct;
   logic                 ev_b_direct;
   logic                 ev_a_cap;
   logic                 ev_b_cap;
   logic                 ev_a_trig;
   logic                 ev_b_trig;

   assign wr_cmd     = bus.wr && (bus.addr == wtc_pkg::ADDR_CMD);
   assign cmd_accept = wr_cmd && |(bus.wdata & wtc_pkg::CMD_MASK)
                     && (cmd_cnt_q == 2'h0);
   assign dis_accept = wr_cmd && bus.wdata[wtc_pkg::B_DIS_EOC]
                     && (en_cnt_q == 2'h0) && !dis_pend_q;
   assign arrive     = (cmd_cnt_q == 2'h1);
   assign restart    = arrive && cmd_q[wtc_pkg::B_RESTART];
   assign cyc_end    = timer_en_q && (phase_q == wtc_pkg::PH_ON_B)
                     && (ph_cnt_q == PHASE_LAST);
   assign cmd_ready  = (cmd_cnt_q == 2'h0);
   assign en_ready   = (en_cnt_q == 2'h0) && !dis_pend_q;

   // software enable and its crossing
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         en_reg_q   <= 1'b0;
         en_cnt_q   <= 2'h0;
         timer_en_q <= 1'b0;
         dis_pend_q <= 1'b0;
      end else begin
         if (bus.wr && (bus.addr == wtc_pkg::ADDR_ENABLE) && en_ready) begin
            en_reg_q <= bus.wdata[0];
            en_cnt_q <= wtc_pkg::SYNC_CYC;
         end else if (en_cnt_q != 2'h0) begin
            en_cnt_q <= en_cnt_q - 2'h1;
            if (en_cnt_q == 2'h1) begin
               timer_en_q <= en_reg_q;
            end
         end
         if (dis_accept) begin
            dis_pend_q <= 1'b1;
         end else if (dis_pend_q && (cyc_end || !timer_en_q)) begin
            dis_pend_q <= 1'b0;
            timer_en_q <= 1'b0;
            en_reg_q   <= 1'b0;
         end
      end
   end

   // command crossing; strobes are consumed, never stored
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         cmd_q     <= 5'h00;
         cmd_cnt_q <= 2'h0;
      end else if (cmd_accept) begin
         cmd_q     <= bus.wdata[4:0];
         cmd_cnt_q <= wtc_pkg::SYNC_CYC;
      end else if (cmd_cnt_q != 2'h0) begin
         cmd_cnt_q <= cmd_cnt_q - 2'h1;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         cap_a_q    <= 1'b0;
         cap_b_q    <= 1'b0;
         load_q     <= 1'b0;
         eoc_pend_q <= 1'b0;
      end else begin
         cap_a_q <= (arrive && cmd_q[wtc_pkg::B_SCAP_A]) || ev_a_cap;
         cap_b_q <= (arrive && cmd_q[wtc_pkg::B_SCAP_B]) || ev_b_cap;
         load_q  <= (arrive && cmd_q[wtc_pkg::B_SYNC])
                 || (eoc_pend_q && cyc_end);
         // a late arrival waits for the following cycle end
         if (arrive && cmd_q[wtc_pkg::B_SYNC_EOC]) begin
            eoc_pend_q <= 1'b1;
         end else if (cyc_end) begin
            eoc_pend_q <= 1'b0;
         end
      end
   end

   // one-ramp counter: four equal phases per cycle
   always_comb begin
      case (phase_q)
         wtc_pkg::PH_DEAD_A: phase_d = wtc_pkg::PH_ON_A;
         wtc_pkg::PH_ON_A:   phase_d = wtc_pkg::PH_DEAD_B;
         wtc_pkg::PH_DEAD_B: phase_d = wtc_pkg::PH_ON_B;
         wtc_pkg::PH_ON_B:   phase_d = wtc_pkg::PH_DEAD_A;
         default:            phase_d = wtc_pkg::PH_DEAD_A;
      endcase
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         ph_cnt_q <= 12'h000;
         phase_q  <= wtc_pkg::PH_DEAD_A;
      end else if (restart) begin
         ph_cnt_q <= 12'h000;
         phase_q  <= wtc_pkg::PH_DEAD_A;
      end else if (timer_en_q) begin
         if (ph_cnt_q == PHASE_LAST) begin
            ph_cnt_q <= 12'h000;
            phase_q  <= phase_d;
         end else begin
            ph_cnt_q <= ph_cnt_q + 12'h001;
         end
      end
   end

   always_comb begin
      wave_d.a = timer_en_q && (phase_q == wtc_pkg::PH_ON_A);
      wave_d.b = timer_en_q && (phase_q == wtc_pkg::PH_ON_B);
      if (ovr_en_q && timer_en_q) begin
         case (phase_q)
            wtc_pkg::PH_DEAD_A: wave_d.a = ovr_val_q[1];
            wtc_pkg::PH_ON_A:   wave_d.a = ovr_val_q[0];
            wtc_pkg::PH_DEAD_B: wave_d.b = ovr_val_q[3];
            wtc_pkg::PH_ON_B:   wave_d.b = ovr_val_q[2];
            default:            wave_d = wave_q;
         endcase
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         wave_q <= '0;
      end else begin
         wave_q <= wave_d;
      end
   end

   // direct event forces the output low at once, no clock involved
   assign waveform.a = wave_q.a & ~ev_a_direct;
   assign waveform.b = wave_q.b & ~ev_b_direct;

   // configuration registers
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         ovr_en_q  <= 1'b0;
         ovr_val_q <= wtc_pkg::REG_RESET;
         ev_a_q    <= wtc_pkg::REG_RESET;
         ev_b_q    <= wtc_pkg::REG_RESET;
         irq_en_q  <= wtc_pkg::REG_RESET;
      end else if (bus.wr) begin
         case (bus.addr)
            wtc_pkg::ADDR_OVR_EN:  ovr_en_q  <= bus.wdata[0];
            wtc_pkg::ADDR_OVR_VAL: ovr_val_q <= bus.wdata;
            wtc_pkg::ADDR_EV_A:    ev_a_q    <= bus.wdata;
            wtc_pkg::ADDR_EV_B:    ev_b_q    <= bus.wdata;
            wtc_pkg::ADDR_IRQ_EN:  irq_en_q  <= bus.wdata & wtc_pkg::IRQ_MASK;
            default:               ovr_en_q  <= ovr_en_q;
         endcase
      end
   end

   wtc_event_ch u_ev_a (
      .ref_clk      (ref_clk),
      .rst_n        (rst_n),
      .ev_in        (event_a_in),
      .cfg          (ev_a_q),
      .fault        (ev_a_fault),
      .direct_fault (ev_a_direct),
      .capture_p    (ev_a_cap),
      .trig_p       (ev_a_trig)
   );

   wtc_event_ch u_ev_b (
      .ref_clk      (ref_clk),
      .rst_n        (rst_n),
      .ev_in        (event_b_in),
      .cfg          (ev_b_q),
      .fault        (ev_b_fault),
      .direct_fault (ev_b_direct),
      .capture_p    (ev_b_cap),
      .trig_p       (ev_b_trig)
   );

   // flags: a set in the clearing cycle survives
   always_comb begin
      flag_set = 8'h00;
      flag_set[wtc_pkg::B_IRQ_OVF]    = cyc_end;
      flag_set[wtc_pkg::B_IRQ_TRIG_A] = ev_a_trig || cap_a_q;
      flag_set[wtc_pkg::B_IRQ_TRIG_B] = ev_b_trig || cap_b_q;
      flag_clr = 8'h00;
      if (bus.wr && (bus.addr == wtc_pkg::ADDR_FLAGS)) begin
         flag_clr = bus.wdata & wtc_pkg::IRQ_MASK;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         flags_q <= wtc_pkg::REG_RESET;
         irq_q   <= 3'h0;
      end else begin
         flags_q <= (flags_q & ~flag_clr) | flag_set;
         irq_q   <= {flags_q[wtc_pkg::B_IRQ_TRIG_B] & irq_en_q[wtc_pkg::B_IRQ_TRIG_B],
                     flags_q[wtc_pkg::B_IRQ_TRIG_A] & irq_en_q[wtc_pkg::B_IRQ_TRIG_A],
                     flags_q[wtc_pkg::B_IRQ_OVF] & irq_en_q[wtc_pkg::B_IRQ_OVF]};
      end
   end

   // read port, data one cycle after the strobe
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata_q <= 8'h00;
      end else if (bus.rd) begin
         case (bus.addr)
            wtc_pkg::ADDR_ENABLE:  rdata_q <= {7'h00, en_reg_q};
            wtc_pkg::ADDR_OVR_EN:  rdata_q <= {7'h00, ovr_en_q};
            wtc_pkg::ADDR_OVR_VAL: rdata_q <= ovr_val_q;
            wtc_pkg::ADDR_CMD:     rdata_q <= 8'h00;
            wtc_pkg::ADDR_EV_A:    rdata_q <= ev_a_q;
            wtc_pkg::ADDR_EV_B:    rdata_q <= ev_b_q;
            wtc_pkg::ADDR_IRQ_EN:  rdata_q <= irq_en_q;
            wtc_pkg::ADDR_FLAGS:   rdata_q <= flags_q;
            wtc_pkg::ADDR_STATUS:  rdata_q <= {6'h00, cmd_ready, en_ready};
            default:               rdata_q <= 8'h00;
         endcase
      end else begin
         rdata_q <= 8'h00;
      end
   end

   assign rdata         = rdata_q;
   assign fault_a       = ev_a_fault;
   assign fault_b       = ev_b_fault;
   assign capture_a     = cap_a_q;
   assign capture_b     = cap_b_q;
   assign buffer_load   = load_q;
   assign timer_running = timer_en_q;
   assign irq_req       = irq_q;

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   cmd_busy_drop_a: assert property (
      wr_cmd && (cmd_cnt_q != 2'h0) |=> (cmd_cnt_q == $past(cmd_cnt_q) - 2'h1))
      else $error("busy command restarted crossing");
   cap_a_time_a: assert property (
      cmd_accept && bus.wdata[wtc_pkg::B_SCAP_A] |-> ##3 capture_a)
      else $error("capture a not three cycles after strobe");
   cap_b_time_a: assert property (
      cmd_accept && bus.wdata[wtc_pkg::B_SCAP_B] |-> ##3 capture_b)
      else $error("capture b not three cycles after strobe");
   restart_zero_a: assert property (
      cmd_accept && bus.wdata[wtc_pkg::B_RESTART]
      |-> ##3 (ph_cnt_q == 12'h000) && (phase_q == wtc_pkg::PH_DEAD_A))
      else $error("counter not restarted");
   sync_load_a: assert property (
      cmd_accept && bus.wdata[wtc_pkg::B_SYNC] |-> ##3 buffer_load)
      else $error("immediate load missing");
   eoc_load_a: assert property (
      buffer_load && !$past(arrive && cmd_q[wtc_pkg::B_SYNC]) |-> $past(cyc_end))
      else $error("buffer load away from cycle end");
   cmd_ready_gap_a: assert property (
      cmd_accept |=> !cmd_ready [*2] ##1 cmd_ready)
      else $error("command ready timing wrong");
   dis_eoc_stop_a: assert property (
      cyc_end && dis_pend_q |=> !timer_en_q && !dis_pend_q && !en_reg_q)
      else $error("timer not stopped at cycle end");
   en_ready_low_a: assert property (
      dis_pend_q && timer_en_q |-> !en_ready ##1 (!en_ready || !timer_en_q))
      else $error("enable ready rose while still running");
   dis_ignored_a: assert property (
      wr_cmd && bus.wdata[wtc_pkg::B_DIS_EOC] && (en_cnt_q != 2'h0) && !dis_pend_q
      |=> !dis_pend_q)
      else $error("disable taken during enable crossing");
   ovr_dead_a_a: assert property (
      ovr_en_q && timer_en_q && (phase_q == wtc_pkg::PH_DEAD_A) |=> wave_q.a == $past(ovr_val_q[1]))
      else $error("waveform a ignores dead time override");
   ovr_on_b_a: assert property (
      ovr_en_q && timer_en_q && (phase_q == wtc_pkg::PH_ON_B) |=> wave_q.b == $past(ovr_val_q[2]))
      else $error("waveform b ignores on time override");
   ovf_flag_a: assert property (
      cyc_end |=> flags_q[wtc_pkg::B_IRQ_OVF])
      else $error("overflow flag not set");
   ovf_irq_a: assert property (
      flags_q[wtc_pkg::B_IRQ_OVF] && irq_en_q[wtc_pkg::B_IRQ_OVF] |=> irq_req[0])
      else $error("overflow interrupt not raised");

   cover_restart_c: cover property (cmd_accept && bus.wdata[wtc_pkg::B_RESTART] ##3 restart);
   cover_eoc_load_c: cover property (eoc_pend_q && cyc_end ##1 buffer_load);
   cover_dis_c: cover property (dis_accept ##[1:200] !timer_en_q);
   cover_busy_c: cover property (wr_cmd && !cmd_ready);
endmodule : wtc_ctrl

// File: hw/wtc_pkg.sv
/*
 waveform timer command and event slice: shared constants and carriers.
 assumes one 100 MHz clock and a plain byte-wide register port.
*/
// What this block does
// - one-ramp override: a takes bit1 dead, bit0 on
// - one-ramp override: b takes bit3 dead, bit2 on
// - command bit 7 disables timer at cycle end
// - enable ready low until timer really stops
// - cycle-end disable ignored during enable crossing
// - command bit 4 fires capture b after crossing
// - command bit 3 fires capture a after crossing
// - commands in bits 4:0 ignored while earlier command still crossing
// - command bit 2 restarts counter after crossing
// - command bit 1 loads buffers after crossing
// - command bit 0 loads buffers at cycle end
// - event bits 7:6 pick sampled, filtered, direct
// - filter changes after four equal samples
// - direct mode drives waveform without sampling
// - event bit 4 picks active edge or level
// - event bit 2 adds capture to fault
// - event a bit 0 enables trigger a
// - event b bit 0 enables trigger b
// - enable bits 3,2 gate trigger b,a interrupts
// - enable bit 0 gates overflow interrupt
// - override applies only with override enable set
// - command ready low until command crosses over
// - overflow flag set at every cycle end
package wtc_pkg;
   localparam logic [7:0] ADDR_ENABLE = 8'h00;
   localparam logic [7:0] ADDR_OVR_EN = 8'h02;
   localparam logic [7:0] ADDR_OVR_VAL = 8'h03;
   localparam logic [7:0] ADDR_CMD = 8'h04;
   localparam logic [7:0] ADDR_EV_A = 8'h08;
   localparam logic [7:0] ADDR_EV_B = 8'h09;
   localparam logic [7:0] ADDR_IRQ_EN = 8'h0C;
   localparam logic [7:0] ADDR_FLAGS = 8'h0D;
   localparam logic [7:0] ADDR_STATUS = 8'h0E;
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam int unsigned B_DIS_EOC = 7;
   localparam int unsigned B_SCAP_B = 4;
   localparam int unsigned B_SCAP_A = 3;
   localparam int unsigned B_RESTART = 2;
   localparam int unsigned B_SYNC = 1;
   localparam int unsigned B_SYNC_EOC = 0;
   localparam int unsigned B_EV_EDGE = 4;
   localparam int unsigned B_EV_ACTION = 2;
   localparam int unsigned B_EV_TRIG = 0;
   localparam int unsigned B_IRQ_TRIG_B = 3;
   localparam int unsigned B_IRQ_TRIG_A = 2;
   localparam int unsigned B_IRQ_OVF = 0;
   localparam logic [7:0] CMD_MASK = 8'h1F;
   localparam logic [7:0] IRQ_MASK = 8'h0D;
   localparam logic [1:0] EV_CFG_NONE = 2'h0;
   localparam logic [1:0] EV_CFG_FILTER = 2'h1;
   localparam logic [1:0] EV_CFG_DIRECT = 2'h2;
   localparam logic [1:0] SYNC_CYC = 2'h2;
   localparam logic [1:0] FILT_LAST = 2'h3;
   typedef enum logic [1:0] {PH_DEAD_A, PH_ON_A, PH_DEAD_B, PH_ON_B} wtc_phase_e;
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } wtc_bus_s;
   typedef struct packed {
      logic a;
      logic b;
   } wtc_wave_s;
endpackage : wtc_pkg

// File: sim/wtc_ctrl_tb_top.sv
/*
 self-checking bench for the waveform timer control slice.
 assumes wtc_pkg, wtc_ctrl and the event source model are compiled first.
*/
`timescale 1ns/10ps
module wtc_ctrl_tb_top;
   logic               ref_clk;
   logic               rst_n;
   wtc_pkg::wtc_bus_s  bus;
   logic [7:0]         rdata;
   logic               ev_a, ev_b, flt_a, flt_b, cap_a, cap_b, bload, running;
   wtc_pkg::wtc_wave_s wave;
   logic [2:0]         irq;
   logic [7:0]         s;
   logic [31:0]        lfsr_q;
   int                 failures, cmp_count, cyc, cnt, first, na, nb;
   int                 shadow [16];
   logic [7:0]         evc [5] = '{8'h15, 8'h05, 8'h55, 8'h11, 8'h55};
   int                 evw [5] = '{8, 8, 8, 8, 2};
   int                 evl [5] = '{3, 3, 6, 0, 0};
   logic [7:0]         ovr [5] = '{8'h0F, 8'h0F, 8'h00, 8'h0C, 8'h03};

   wtc_ctrl #(.PHASE_LEN(12'h004)) i_dut (.ref_clk(ref_clk), .rst_n(rst_n), .bus(bus),
      .rdata(rdata), .event_a_in(ev_a), .event_b_in(ev_b), .waveform(wave),
      .fault_a(flt_a), .fault_b(flt_b), .capture_a(cap_a), .capture_b(cap_b),
      .buffer_load(bload), .timer_running(running), .irq_req(irq));
   wtc_event_src i_src (.ref_clk(ref_clk), .ev_a(ev_a), .ev_b(ev_b));

   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   // a hang ends the run through the normal report
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 30000) begin
         failures++;
         report_and_stop();
      end
   end

   function automatic logic [31:0] nxt(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction : nxt
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      cmp_count++;
      if (g !== e) begin
         failures++;
         $display("ERROR %s expected %0h seen %0h", n, e, g);
      end
   endtask : chk
   task automatic wt(input int n);
      repeat (n) @(posedge ref_clk);
   endtask : wt
   task automatic bwr(input logic [7:0] a, input logic [7:0] d, input bit hold = 0);
      if (a == wtc_pkg::ADDR_EV_A || a == wtc_pkg::ADDR_EV_B) shadow[a[3:0]] = d;
      if (a == wtc_pkg::ADDR_IRQ_EN) shadow[12] = d & wtc_pkg::IRQ_MASK;
      @(posedge ref_clk);
      bus <= '{a, d, 1'b1, 1'b0};
      if (!hold) begin
         @(posedge ref_clk);
         bus.wr <= 1'b0;
      end
   endtask : bwr
   task automatic brd(input logic [7:0] a, output logic [7:0] d);
      @(posedge ref_clk);
      bus <= '{a, 8'h00, 1'b0, 1'b1};
      @(posedge ref_clk);
      bus.rd <= 1'b0;
      #1 d = rdata;
   endtask : brd
   // sel 3 skips the old phase still showing before a restart lands
   task automatic mon(input int sel, input int n);
      cnt = 0;
      first = 0;
      for (int i = 1; i <= n; i++) begin
         @(posedge ref_clk);
         #1;
         if ((sel == 0 ? cap_a : sel == 1 ? cap_b : sel == 2 ? bload : wave.a) === 1'b1) begin
            if (first == 0 && (sel < 3 || i > 4)) first = i;
            cnt++;
         end
      end
   endtask : mon
   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : report_and_stop

   initial begin
      bus = '0;
      rst_n = 1'b0;
      lfsr_q = 32'd80588;
      wt(20);
      rst_n <= 1'b1;
      foreach (shadow[k]) shadow[k] = 0;
      for (int a = 4; a < 14; a++) begin
         brd(8'(a), s);
         chk("reset value", 8'h00, s);
      end
      brd(8'h20, s);
      chk("unmapped", 8'h00, s);
      repeat (4) begin
         lfsr_q = nxt(lfsr_q);
         bwr(wtc_pkg::ADDR_EV_A, lfsr_q[7:0] & 8'h55);
         bwr(wtc_pkg::ADDR_EV_B, lfsr_q[15:8] & 8'h55);
         bwr(wtc_pkg::ADDR_IRQ_EN, lfsr_q[23:16]);
         for (int a = 8; a < 13; a = (a == 9) ? 12 : a + 1) begin
            brd(8'(a), s);
            chk("readback", 8'(shadow[a]), s);
         end
      end
      bwr(wtc_pkg::ADDR_EV_A, 8'h00);
      bwr(wtc_pkg::ADDR_EV_B, 8'h00);
      bwr(wtc_pkg::ADDR_ENABLE, 8'h01, 1);
      bwr(wtc_pkg::ADDR_CMD, 8'h80);
      wt(40);
      chk("running", 8'h01, running);
      for (int k = 0; k < 3; k++) begin
         bwr(wtc_pkg::ADDR_CMD, (k == 2) ? 8'h02 : 8'h08 << k);
         mon(k, 8);
         chk("pulse count", 8'h01, 8'(cnt));
         chk("pulse cycle", 8'h02, 8'(first));
         wt(4);
      end
      bwr(wtc_pkg::ADDR_CMD, 8'h08, 1);
      bwr(wtc_pkg::ADDR_CMD, 8'h10);
      mon(1, 8);
      chk("busy command", 8'h00, 8'(cnt));
      bwr(wtc_pkg::ADDR_CMD, 8'h02);
      brd(wtc_pkg::ADDR_STATUS, s);
      chk("ready busy", 8'h00, s[1]);
      wt(4);
      brd(wtc_pkg::ADDR_STATUS, s);
      chk("ready", 8'h01, s[1]);
      brd(wtc_pkg::ADDR_CMD, s);
      chk("command readback", 8'h00, s);
      bwr(wtc_pkg::ADDR_CMD, 8'h01);
      mon(2, 24);
      chk("eoc load count", 8'h01, 8'(cnt));
      chk("eoc load late", 8'h01, first >= 3 && first <= 18);
      bwr(wtc_pkg::ADDR_CMD, 8'h04);
      mon(3, 12);
      chk("restart phase", 8'h01, first >= 7 && first <= 9);
      foreach (ovr[k]) begin
         bwr(wtc_pkg::ADDR_OVR_EN, {7'h00, k != 0});
         bwr(wtc_pkg::ADDR_OVR_VAL, ovr[k]);
         wt(20);
         na = 0;
         nb = 0;
         repeat (16) begin
            @(posedge ref_clk);
            #1;
            na += (wave.a === 1'b1);
            nb += (wave.b === 1'b1);
         end
         chk("wave a", k ? 8'(4 * (int'(ovr[k][1]) + int'(ovr[k][0]))) : 8'h04, 8'(na));
         chk("wave b", k ? 8'(4 * (int'(ovr[k][3]) + int'(ovr[k][2]))) : 8'h04, 8'(nb));
      end
      bwr(wtc_pkg::ADDR_IRQ_EN, 8'h0D);
      wt(20);
      brd(wtc_pkg::ADDR_FLAGS, s);
      chk("cycle flag", 8'h01, s[0]);
      chk("cycle irq", 8'h01, irq[0]);
      bwr(wtc_pkg::ADDR_IRQ_EN, 8'h0C);
      wt(3);
      chk("cycle irq masked", 8'h00, irq[0]);
      for (int ch = 0; ch < 2; ch++) begin
         foreach (evc[k]) begin
            bwr(wtc_pkg::ADDR_EV_A + 8'(ch), evc[k]);
            i_src.set_line(ch, !evc[k][4]);
            wt(10);
            bwr(wtc_pkg::ADDR_FLAGS, 8'h0D);
            i_src.set_line(ch, evc[k][4]);
            fork
               begin
                  wt(evw[k] - 1);
                  i_src.set_line(ch, !evc[k][4]);
               end
               mon(ch, 12);
            join
            chk("event capture", 8'(evl[k]), 8'(first));
            wt(6);
            brd(wtc_pkg::ADDR_FLAGS, s);
            chk("trigger flag", 8'(k != 4), s[2 + ch]);
            chk("trigger irq", 8'(k != 4), irq[1 + ch]);
         end
      end
      bwr(wtc_pkg::ADDR_EV_A, 8'h90);
      i_src.set_line(0, 1'b1);
      #1 chk("direct fault", 8'h01, flt_a);
      mon(3, 16);
      chk("direct gate", 8'h00, 8'(cnt));
      i_src.set_line(0, 1'b0);
      bwr(wtc_pkg::ADDR_EV_B, 8'h90);
      i_src.set_line(1, 1'b1);
      #1 chk("direct fault b", 8'h01, flt_b);
      i_src.set_line(1, 1'b0);
      bwr(wtc_pkg::ADDR_CMD, 8'h80);
      repeat (12) begin
         brd(wtc_pkg::ADDR_STATUS, s);
         if (running === 1'b1) chk("enable ready low", 8'h00, s[0]);
      end
      chk("stopped", 8'h00, running);
      brd(wtc_pkg::ADDR_STATUS, s);
      chk("enable ready", 8'h01, s[0]);
      report_and_stop();
   end
endmodule : wtc_ctrl_tb_top

// File: sim/wtc_event_src.sv
/*
 event line source standing in for the peripheral event inputs.
 assumes the bench calls set_line from its clocked sequence.
*/
`timescale 1ns/10ps
module wtc_event_src (
   input  wire logic ref_clk,
   output logic      ev_a,
   output logic      ev_b
);
   initial begin
      ev_a = 1'b0;
      ev_b = 1'b0;
   end
   // levels move just after an edge, like a synchronous event source
   task automatic set_line(input int ch, input logic v);
      @(posedge ref_clk);
      if (ch == 0) begin
         ev_a <= v;
      end else begin
         ev_b <= v;
      end
   endtask : set_line
endmodule : wtc_event_src
